/* File: pkg/cis_pkg.sv */
// Constants and types for the command input scaling block.
// Assumes a 32-bit AHB-Lite register bus and converter samples synchronous to hclk.
// Notes on behaviour
// [R1] Mode and scaling parameters change only while the block is disabled.
// [R2] Four modes: unipolar one solenoid, split, bipolar, input-selected solenoid.
// [R3] Selecting a mode may swap the signal type to a compatible one.
// [R4] Types 0-10 V, +/-10 V, 0-20 mA, 4-20 mA; only mode-valid ones allowed.
// [R5] Voltage or current input is chosen from the signal type.
// [R6] Optional inversion of the input value before use as command.
// [R7] Cable-break detection can be switched on or off.
// [R8] Gain in 0.001 % steps per volt or milliampere, up to 100 %.
// [R9] A signal type change reloads the default gain for type and mode.
// [R10] A non-default gain may give under ten bits of resolution.
// [R11] Offset sets zero point: 0.01 V steps to 10 V, 0.02 mA to 20 mA.
// [R12] Default gains 10 %/V, 20 %/V split, 10 %/V bipolar, 6.25 %/mA.
// [R13] Command is input minus offset, times gain, inverted, limited 0-100 %.
// [R14] Cable-break flag when enabled and current falls below the live zero.
package cis_pkg;
   typedef enum logic [1:0] {MODE_UNI1, MODE_UNI2, MODE_BIP2, MODE_UNI_DIG} cis_mode_type;
   typedef enum logic [1:0] {SIG_V10, SIG_VBIP, SIG_MA20, SIG_MA4_20} cis_sig_type;
   typedef enum logic {ST_DISABLED, ST_ENABLED} cis_state_type;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_SIGT = 8'h08;
   localparam logic [7:0] ADDR_CFG = 8'h0C;
   localparam logic [7:0] ADDR_GAIN = 8'h10;
   localparam logic [7:0] ADDR_OFFS = 8'h14;
   localparam logic [7:0] ADDR_INPUT = 8'h18;
   localparam logic [7:0] ADDR_CMD = 8'h1C;
   localparam logic [7:0] ADDR_STAT = 8'h20;
   localparam logic [7:0] ADDR_MASK = 8'h24;
   localparam logic [7:0] ADDR_FLAGS = 8'h28;
   // Field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CFG_INV_BIT = 0;
   localparam int CFG_CB_BIT = 1;
   localparam int EV_CB = 0;
   localparam int EV_REFUSE = 1;
   localparam int EV_AUTO = 2;
   localparam int EV_W = 3;
   localparam int FL_CB = 0;
   localparam int FL_LOWRES = 1;
   localparam int FL_CURR = 2;
   localparam int FL_LIMIT = 3;
   localparam int CMD_NEG_BIT = 16;
   // Widths and scales: voltage in mV, current in uA, gain in 0.001 %/unit
   localparam int IN_W = 16;
   localparam int GAIN_W = 17;
   localparam int OFFS_W = 11;
   localparam int CMD_W = 14;
   localparam int PROD_W = IN_W + GAIN_W + 2;
   localparam logic [GAIN_W-1:0] GAIN_MIN = 17'h00001;
   localparam logic [GAIN_W-1:0] GAIN_MAX = 17'h186A0;
   localparam logic signed [OFFS_W-1:0] OFFS_MAX = 11'sh3E8;
   localparam logic signed [IN_W-1:0] OFFS_MV_STEP = 16'sh000A;
   localparam logic signed [IN_W-1:0] OFFS_UA_STEP = 16'sh0014;
   localparam logic [CMD_W-1:0] CMD_FULL = 14'h2710;
   localparam logic [CMD_W-1:0] CMD_HALF = 14'h1388;
   localparam int SCALE_DIV = 10000;
   localparam int CB_LIVE_ZERO_UA = 3600;
   // Default gains
   localparam logic [GAIN_W-1:0] G_10_PV = 17'h02710;
   localparam logic [GAIN_W-1:0] G_20_PV = 17'h04E20;
   localparam logic [GAIN_W-1:0] G_5_PMA = 17'h01388;
   localparam logic [GAIN_W-1:0] G_625_PMA = 17'h0186A;
   localparam logic [GAIN_W-1:0] G_10_PMA = 17'h02710;
   localparam logic [GAIN_W-1:0] G_125_PMA = 17'h030D4;
   // Reset values
   localparam logic [GAIN_W-1:0] GAIN_RST = G_10_PV;

   // Default gain for a mode and signal type
   function automatic logic [GAIN_W-1:0] default_gain(cis_mode_type m, cis_sig_type s);
      logic two;
      two = (m == MODE_UNI2);
      case (s)
         SIG_V10: default_gain = two ? G_20_PV : G_10_PV;
         SIG_VBIP: default_gain = G_10_PV;
         SIG_MA20: default_gain = two ? G_10_PMA : G_5_PMA;
         default: default_gain = two ? G_125_PMA : G_625_PMA;
      endcase
   endfunction

   // Signal type allowed in a mode
   function automatic logic sig_ok(cis_mode_type m, cis_sig_type s);
      sig_ok = ((m == MODE_BIP2) == (s == SIG_VBIP));
   endfunction

   // Nearest compatible signal type after a mode change
   function automatic cis_sig_type compat_sig(cis_mode_type m, cis_sig_type s);
      if (sig_ok(m, s))
         compat_sig = s;
      else if (m == MODE_BIP2)
         compat_sig = SIG_VBIP;
      else
         compat_sig = SIG_V10;
   endfunction
endpackage

/* File: pkg/cis_if.sv */
// Carrier between the register side and the scaling engine.
// Assumes both ends share hclk.
`timescale 1ns/100ps
interface cis_if;
   import cis_pkg::*;
   logic signed [IN_W:0] diff;
   logic [GAIN_W-1:0] gain;
   logic invert;
   logic bipolar;
   logic [CMD_W-1:0] cmd;
   logic neg;
   logic limited;
   modport ctl (output diff, gain, invert, bipolar, input cmd, neg, limited);
   modport eng (input diff, gain, invert, bipolar, output cmd, neg, limited);
endinterface

/* File: rtl/cis_scale.sv */
// Two-stage gain, inversion and limiting engine.
// Assumes the inputs in the carrier are stable or registered by the caller.
`timescale 1ns/100ps
module cis_scale
   import cis_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   cis_if.eng bus
);
   import cis_pkg::*;
   localparam logic signed [PROD_W-1:0] DIV_S = PROD_W'(SCALE_DIV);
   logic signed [PROD_W-1:0] prod_q;
   logic signed [PROD_W-1:0] prod_raw;
   logic signed [PROD_W-1:0] quo;
   logic signed [PROD_W-1:0] full_s;
   logic [CMD_W-1:0] cmd_q;
   logic neg_q;
   logic lim_q;

   assign prod_raw = PROD_W'(bus.diff) * PROD_W'($signed({1'b0, bus.gain}));
   assign quo = prod_q / DIV_S;
   assign full_s = PROD_W'($signed({1'b0, CMD_FULL}));

   // Product stage with optional inversion after the gain
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         prod_q <= '0;
      else if (bus.invert)
         prod_q <= -prod_raw; // R6
      else
         prod_q <= prod_raw; // R13
   end

   // Divide to 0.01 % units and limit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cmd_q <= '0;
         neg_q <= 1'b0;
         lim_q <= 1'b0;
      end
      else if (bus.bipolar && quo < 0)
      begin
         neg_q <= 1'b1;
         lim_q <= (-quo > full_s);
         cmd_q <= (-quo > full_s) ? CMD_FULL : CMD_W'(-quo); // R13
      end
      else
      begin
         neg_q <= 1'b0;
         lim_q <= (quo < 0) || (quo > full_s);
         cmd_q <= (quo < 0) ? '0 : (quo > full_s) ? CMD_FULL : CMD_W'(quo); // R13
      end
   end

   assign bus.cmd = cmd_q;
   assign bus.neg = neg_q;
   assign bus.limited = lim_q;
endmodule

/* File: rtl/cis_top.sv */
// Command input scaling block: AHB-Lite registers, routing, offset, cable break.
// Assumes converter samples arrive synchronous to hclk, voltage in mV, current in uA.
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module cis_top
   import cis_pkg::*;
#(
   parameter int CB_THRESH_UA = CB_LIVE_ZERO_UA
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic signed [cis_pkg::IN_W-1:0] volt_in,
   input wire logic signed [cis_pkg::IN_W-1:0] curr_in,
   input wire logic sol_b_select,
   output logic [cis_pkg::CMD_W-1:0] cmd_value,
   output logic [cis_pkg::CMD_W-1:0] sol_a_cmd,
   output logic [cis_pkg::CMD_W-1:0] sol_b_cmd,
   output logic enabled,
   output logic cable_break,
   output logic irq
);
   import cis_pkg::*;

   // Threshold must sit inside the live-zero band of a 4-20 mA loop
   generate
      if (CB_THRESH_UA < 1 || CB_THRESH_UA > 4000)
      begin : g_bad_thresh
         $error("CB_THRESH_UA out of range");
      end
   endgenerate

   localparam logic signed [IN_W-1:0] CB_THR = IN_W'(CB_THRESH_UA);

   // Bus state
   logic wr_q;
   logic rd_q;
   logic rd_done_q;
   logic [7:0] addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rdata;
   logic take;
   logic hit;

   // Configuration state
   cis_state_type state_q;
   cis_mode_type mode_q;
   cis_mode_type mode_d;
   cis_sig_type sig_q;
   cis_sig_type sig_d;
   logic [GAIN_W-1:0] gain_q;
   logic [GAIN_W-1:0] gain_d;
   logic signed [OFFS_W-1:0] offs_q;
   logic inv_q;
   logic cb_en_q;
   logic [EV_W-1:0] stat_q;
   logic [EV_W-1:0] mask_q;
   logic [EV_W-1:0] events;
   logic refuse;
   logic auto_ev;
   logic offs_refuse;
   logic cfg_refuse;
   logic wr_ok;
   logic signed [OFFS_W-1:0] offs_new;

   // Datapath state
   logic use_curr;
   logic signed [IN_W-1:0] in_q;
   logic signed [IN_W-1:0] offs_native;
   logic cb_now;
   logic cb_q;
   logic [CMD_W-1:0] cmd_q;
   logic [CMD_W-1:0] sol_a_q;
   logic [CMD_W-1:0] sol_b_q;
   logic [CMD_W:0] split_lo;
   logic [CMD_W:0] split_hi;

   cis_if sc ();

   cis_scale u_scale (
      .hclk(hclk),
      .hresetn(hresetn),
      .bus(sc.eng)
   );

   // Address phase decode: whole-word transfers; writes in the low block only, reads elsewhere return zero
   assign take = hsel && hready && htrans[1] && (hsize == 3'h2);
   assign hit = (haddr[31:8] == 24'h000000);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 8'h00;
      end
      else if (hready)
      begin
         wr_q <= take && hwrite && hit;
         rd_q <= take && !hwrite;
         addr_q <= hit ? haddr[7:0] : 8'hFF;
      end
   end

   // Reads take one wait state so that data come from a flip-flop
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_done_q <= 1'b0;
         hrdata_q <= 32'h00000000;
      end
      else if (rd_q && !rd_done_q)
      begin
         rd_done_q <= 1'b1;
         hrdata_q <= rdata;
      end
      else
         rd_done_q <= 1'b0;
   end

   assign hreadyout = !(rd_q && !rd_done_q);
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // Parameter writes land only while disabled
   assign wr_ok = wr_q && (state_q == ST_DISABLED); // R1

   // Enable state machine
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state_q <= ST_DISABLED;
      else if (wr_q && addr_q == ADDR_CTRL)
      begin
         case (state_q)
            ST_DISABLED: state_q <= hwdata[CTRL_EN_BIT] ? ST_ENABLED : ST_DISABLED;
            ST_ENABLED: state_q <= hwdata[CTRL_EN_BIT] ? ST_ENABLED : ST_DISABLED;
            default: state_q <= ST_DISABLED;
         endcase
      end
   end

   // Next mode, signal type and gain
   always_comb
   begin
      mode_d = mode_q;
      sig_d = sig_q;
      gain_d = gain_q;
      refuse = 1'b0;
      auto_ev = 1'b0;
      if (wr_q && !wr_ok)
         refuse = (addr_q == ADDR_MODE) || (addr_q == ADDR_SIGT) || (addr_q == ADDR_GAIN); // R1
      else if (wr_ok)
      begin
         case (addr_q)
            ADDR_MODE:
            begin
               mode_d = cis_mode_type'(hwdata[1:0]); // R2
               sig_d = compat_sig(mode_d, sig_q); // R3
               auto_ev = (sig_d != sig_q);
            end
            ADDR_SIGT:
            begin
               if (sig_ok(mode_q, cis_sig_type'(hwdata[1:0])))
                  sig_d = cis_sig_type'(hwdata[1:0]); // R4
               else
                  refuse = 1'b1; // R4
            end
            ADDR_GAIN:
            begin
               if (hwdata[31:GAIN_W] == '0 && hwdata[GAIN_W-1:0] >= GAIN_MIN
                   && hwdata[GAIN_W-1:0] <= GAIN_MAX)
                  gain_d = hwdata[GAIN_W-1:0]; // R8
               else
                  refuse = 1'b1;
            end
            default:
            begin
               refuse = 1'b0;
            end
         endcase
      end
      if (sig_d != sig_q)
         gain_d = default_gain(mode_d, sig_d); // R9 R12
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mode_q <= MODE_UNI1;
         sig_q <= SIG_V10;
         gain_q <= GAIN_RST;
      end
      else
      begin
         mode_q <= mode_d;
         sig_q <= sig_d;
         gain_q <= gain_d;
      end
   end

   // Offset: signed steps of 10 mV or 20 uA, at most 1000 steps either way
   assign offs_new = hwdata[OFFS_W-1:0];
   assign offs_refuse = wr_q && addr_q == ADDR_OFFS
                        && (!wr_ok || offs_new > OFFS_MAX || offs_new < -OFFS_MAX);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         offs_q <= '0;
      else if (wr_ok && addr_q == ADDR_OFFS && !offs_refuse)
         offs_q <= offs_new; // R11
   end

   // Inversion and cable-break switches
   assign cfg_refuse = wr_q && !wr_ok && addr_q == ADDR_CFG;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         inv_q <= 1'b0;
         cb_en_q <= 1'b0;
      end
      else if (wr_ok && addr_q == ADDR_CFG)
      begin
         inv_q <= hwdata[CFG_INV_BIT]; // R6
         cb_en_q <= hwdata[CFG_CB_BIT]; // R7
      end
   end

   // Input routing and sampling
   assign use_curr = (sig_q == SIG_MA20) || (sig_q == SIG_MA4_20);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         in_q <= '0;
      else
         in_q <= use_curr ? curr_in : volt_in; // R5
   end

   // Offset in input units, then the engine operands
   assign offs_native = IN_W'(offs_q * (use_curr ? OFFS_UA_STEP : OFFS_MV_STEP)); // R11
   assign sc.diff = (IN_W+1)'(in_q) - (IN_W+1)'(offs_native); // R13
   assign sc.gain = gain_q;
   assign sc.invert = inv_q;
   assign sc.bipolar = (mode_q == MODE_BIP2);

   // Cable break on the live-zero current loop
   assign cb_now = cb_en_q && (sig_q == SIG_MA4_20) && (curr_in < CB_THR); // R14

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cb_q <= 1'b0;
      else
         cb_q <= cb_now; // R14
   end

   // Command and solenoid distribution, forced to zero when disabled or broken
   assign split_lo = (CMD_W+1)'({1'b0, CMD_HALF - sc.cmd} << 1);
   assign split_hi = (CMD_W+1)'({1'b0, sc.cmd - CMD_HALF} << 1);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cmd_q <= '0;
         sol_a_q <= '0;
         sol_b_q <= '0;
      end
      else if (state_q != ST_ENABLED || cb_q)
      begin
         cmd_q <= '0;
         sol_a_q <= '0;
         sol_b_q <= '0;
      end
      else
      begin
         cmd_q <= sc.cmd;
         case (mode_q)
            MODE_UNI1:
            begin
               sol_a_q <= sc.cmd; // R2
               sol_b_q <= '0;
            end
            MODE_UNI2:
            begin
               sol_a_q <= (sc.cmd < CMD_HALF) ? CMD_W'(split_lo) : '0; // R2
               sol_b_q <= (sc.cmd < CMD_HALF) ? '0 : CMD_W'(split_hi);
            end
            MODE_BIP2:
            begin
               sol_a_q <= sc.neg ? '0 : sc.cmd; // R2
               sol_b_q <= sc.neg ? sc.cmd : '0;
            end
            default:
            begin
               sol_a_q <= sol_b_select ? '0 : sc.cmd; // R2
               sol_b_q <= sol_b_select ? sc.cmd : '0;
            end
         endcase
      end
   end

   assign cmd_value = cmd_q;
   assign sol_a_cmd = sol_a_q;
   assign sol_b_cmd = sol_b_q;
   assign enabled = (state_q == ST_ENABLED);
   assign cable_break = cb_q;

   // Sticky events; a new event wins over a write-one clear
   assign events[EV_CB] = cb_now && !cb_q;
   assign events[EV_REFUSE] = refuse || offs_refuse || cfg_refuse;
   assign events[EV_AUTO] = auto_ev;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         stat_q <= '0;
      else if (wr_q && addr_q == ADDR_STAT)
         stat_q <= (stat_q & ~hwdata[EV_W-1:0]) | events;
      else
         stat_q <= stat_q | events;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mask_q <= '0;
      else if (wr_q && addr_q == ADDR_MASK)
         mask_q <= hwdata[EV_W-1:0];
   end

   assign irq = |(stat_q & mask_q);

   // Read multiplexer; unmapped offsets read as zero
   always_comb
   begin
      rdata = 32'h00000000;
      case (addr_q)
         ADDR_CTRL: rdata[CTRL_EN_BIT] = (state_q == ST_ENABLED);
         ADDR_MODE: rdata[1:0] = mode_q;
         ADDR_SIGT: rdata[1:0] = sig_q;
         ADDR_CFG:
         begin
            rdata[CFG_INV_BIT] = inv_q;
            rdata[CFG_CB_BIT] = cb_en_q;
         end
         ADDR_GAIN: rdata[GAIN_W-1:0] = gain_q;
         ADDR_OFFS: rdata = 32'(offs_q);
         ADDR_INPUT: rdata = 32'(in_q);
         ADDR_CMD:
         begin
            rdata[CMD_W-1:0] = cmd_q;
            rdata[CMD_NEG_BIT] = sc.neg;
         end
         ADDR_STAT: rdata[EV_W-1:0] = stat_q;
         ADDR_MASK: rdata[EV_W-1:0] = mask_q;
         ADDR_FLAGS:
         begin
            rdata[FL_CB] = cb_q;
            rdata[FL_LOWRES] = (gain_q != default_gain(mode_q, sig_q)); // R10
            rdata[FL_CURR] = use_curr;
            rdata[FL_LIMIT] = sc.limited;
         end
         default: rdata = 32'h00000000;
      endcase
   end
endmodule

/* File: dv/cis_checker.sv */
// Port checker for the command input scaling block.
// Assumes it is bound into every cis_top instance and shares its clock and reset.
`timescale 1ns/100ps
module cis_checker
   import cis_pkg::*;
#(
   parameter int CB_THRESH_UA = CB_LIVE_ZERO_UA
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic signed [cis_pkg::IN_W-1:0] curr_in,
   input wire logic [cis_pkg::CMD_W-1:0] cmd_value,
   input wire logic [cis_pkg::CMD_W-1:0] sol_a_cmd,
   input wire logic [cis_pkg::CMD_W-1:0] sol_b_cmd,
   input wire logic enabled,
   input wire logic cable_break
);
   logic rd_t;
   logic wr_t;
   logic any_cmd;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Transfer decode and command activity
   assign rd_t = hsel && hready && htrans[1] && !hwrite;
   assign wr_t = hsel && hready && htrans[1] && hwrite;
   assign any_cmd = (cmd_value | sol_a_cmd | sol_b_cmd) != '0;
   resp_okay_a: assert property (hresp == 1'b0) else $error("bus response not okay");
   read_wait_a: assert property (rd_t |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
   write_zero_a: assert property (wr_t |=> hreadyout) else $error("write data phase stalled");
   cmd_limit_a: assert property (cmd_value <= CMD_FULL && sol_a_cmd <= CMD_FULL && sol_b_cmd <= CMD_FULL)
      else $error("command above full scale");
   sol_excl_a: assert property (sol_a_cmd == '0 || sol_b_cmd == '0) else $error("both solenoids driven");
   off_zero_a: assert property (!enabled [*5] |-> !any_cmd) else $error("command while disabled");
   cb_zero_a: assert property (cable_break [*2] |-> !any_cmd) else $error("command during cable break");
   cb_cause_a: assert property ($rose(cable_break) |-> $past(curr_in) < CB_THRESH_UA)
      else $error("cable break without low current");
   cover property (rd_t);
   cover property ($rose(cable_break));
   cover property (sol_b_cmd != '0);
   cover property (cmd_value == CMD_FULL);
endmodule

bind cis_top cis_checker #(.CB_THRESH_UA(CB_THRESH_UA)) i_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .curr_in, .cmd_value, .sol_a_cmd, .sol_b_cmd, .enabled, .cable_break);

/* File: dv/cis_src_model.sv */
// Analogue command source: voltage, current and solenoid select samples.
// Assumes the bench sets targets; outputs follow each edge, or every second edge when slow.
`timescale 1ns/100ps
module cis_src_model
   import cis_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic slow,
   input wire logic signed [cis_pkg::IN_W-1:0] set_mv,
   input wire logic signed [cis_pkg::IN_W-1:0] set_ua,
   input wire logic set_sel,
   output logic signed [cis_pkg::IN_W-1:0] volt_in,
   output logic signed [cis_pkg::IN_W-1:0] curr_in,
   output logic sol_b_select
);
   logic tick_q;
   // Samples settle late when slow, as a sluggish converter would
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tick_q <= 1'b0;
         volt_in <= '0;
         curr_in <= '0;
         sol_b_select <= 1'b0;
      end
      else
      begin
         tick_q <= !tick_q;
         if (!slow || tick_q)
         begin
            volt_in <= set_mv;
            curr_in <= set_ua;
            sol_b_select <= set_sel;
         end
      end
   end
endmodule

/* File: dv/command_input_scaling_tb_top.sv */
// Self-checking bench for cis_top over AHB-Lite with an analogue source model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/100ps
module command_input_scaling_tb_top;
   import cis_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0, set_sel = 1'b0, rd_dp = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, enabled, cable_break, irq, sol_b_select;
   logic signed [IN_W-1:0] volt_in, curr_in, set_mv = '0, set_ua = '0;
   logic [CMD_W-1:0] cmd_value, sol_a_cmd, sol_b_cmd;
   logic [15:0] lfsr = 16'h004B;
   int failures = 0, checked = 0;
   typedef struct {string n; logic [31:0] v;} cis_note_type;
   cis_note_type notes[$];
   logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24};
   logic [1:0] md[3] = '{2'h0, 2'h1, 2'h3};
   logic [31:0] sc[3] = '{32'h0, 32'h2, 32'h3};
   int gt[2][3] = '{'{10000, 5000, 6250}, '{20000, 10000, 12500}};
   logic [31:0] gv[4] = '{32'h0, 32'h186A1, 32'h186A0, 32'h1};
   logic [31:0] ge[4] = '{32'h2710, 32'h2710, 32'h186A0, 32'h1};

   cis_top #(.CB_THRESH_UA(3600)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .volt_in(volt_in), .curr_in(curr_in),
      .sol_b_select(sol_b_select), .cmd_value(cmd_value), .sol_a_cmd(sol_a_cmd), .sol_b_cmd(sol_b_cmd),
      .enabled(enabled), .cable_break(cable_break), .irq(irq));
   cis_src_model i_src (.hclk(hclk), .hresetn(hresetn), .slow(slow), .set_mv(set_mv), .set_ua(set_ua),
      .set_sel(set_sel), .volt_in(volt_in), .curr_in(curr_in), .sol_b_select(sol_b_select));

   // Clock
   always #2.5 hclk = ~hclk;

   task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("Counts: checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Waits for hready at a rising edge, bounded
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 40)
      begin
         @(posedge hclk);
         n++;
      end
      if (hreadyout !== 1'b1)
      begin
         failures++;
         stop_test();
      end
   endtask

   task automatic bus(logic w, logic hi, logic [7:0] a, logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {23'h0, hi, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask

   task automatic rd(string n, logic [7:0] a, logic [31:0] e);
      notes.push_back('{n, e});
      bus(1'b0, 1'b0, a, 32'h0);
   endtask

   task automatic src(int mv, int ua, logic sel);
      set_mv <= mv[15:0];
      set_ua <= ua[15:0];
      set_sel <= sel;
      repeat (10) @(posedge hclk);
   endtask

   task automatic sol(logic [31:0] m, int mv, logic sel, int c, int a, int b);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_MODE, m);
      wr(ADDR_CTRL, 32'h1);
      src(mv, 0, sel);
      check("command", 32'(cmd_value), c);
      check("solenoid a", 32'(sol_a_cmd), a);
      check("solenoid b", 32'(sol_b_cmd), b);
   endtask

   function automatic int scale(int x, int g, bit inv);
      int p;
      p = x * g / 10000;
      if (inv)
         p = -p;
      return (p < 0) ? 0 : ((p > 10000) ? 10000 : p);
   endfunction

   function automatic int rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return int'(lfsr);
   endfunction

   // Read data is compared with the oldest note as each read completes
   always @(posedge hclk)
   begin
      if (rd_dp && hreadyout === 1'b1 && notes.size() > 0)
      begin
         check(notes[0].n, hrdata, notes[0].v);
         void'(notes.pop_front());
      end
      if (hreadyout === 1'b1)
         rd_dp <= hsel && htrans[1] && !hwrite;
   end

   // Main sequence
   initial
   begin
      int mv, o, g;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (ra[i])
         rd("reset value", ra[i], (ra[i] == ADDR_GAIN) ? 32'h2710 : 32'h0);
      notes.push_back('{"unmapped", 32'h0});
      bus(1'b0, 1'b1, 8'h00, 32'h0);
      $display("Test reset finished");
      foreach (md[k])
      begin
         wr(ADDR_MODE, {30'h0, md[k]});
         for (int s = 1; s < 4; s++)
         begin
            wr(ADDR_SIGT, sc[s % 3]);
            rd("default gain", ADDR_GAIN, gt[md[k] == 2'h1][s % 3]);
         end
      end
      wr(ADDR_MODE, 32'h2);
      rd("auto type", ADDR_SIGT, 32'h1);
      rd("bipolar gain", ADDR_GAIN, 32'h2710);
      wr(ADDR_SIGT, 32'h0);
      rd("type refused", ADDR_STAT, 32'h6);
      wr(ADDR_CTRL, 32'h1);
      wr(ADDR_GAIN, 32'h4D2);
      rd("gain while enabled", ADDR_GAIN, 32'h2710);
      check("enabled", 32'(enabled), 32'h1);
      wr(ADDR_CTRL, 32'h0);
      foreach (gv[i])
      begin
         wr(ADDR_GAIN, gv[i]);
         rd("gain range", ADDR_GAIN, ge[i]);
      end
      rd("low resolution", ADDR_FLAGS, 32'h2);
      wr(ADDR_OFFS, 32'h3E9);
      rd("offset above range", ADDR_OFFS, 32'h0);
      wr(ADDR_OFFS, 32'hFFFFFC18);
      rd("offset low end", ADDR_OFFS, 32'hFFFFFC18);
      wr(ADDR_STAT, 32'h7);
      $display("Test configuration finished");
      wr(ADDR_MODE, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         mv = rnd() % 11000;
         o = i[0] ? 900 : -100 * i;
         g = 5000 + 5000 * i;
         wr(ADDR_CTRL, 32'h0);
         wr(ADDR_OFFS, o);
         wr(ADDR_GAIN, g);
         wr(ADDR_CFG, {31'h0, i[0]});
         wr(ADDR_CTRL, 32'h1);
         src(mv, 20000 - mv, 1'b0);
         check("scaled command", 32'(cmd_value), scale(mv - o * 10, g, i[0]));
      end
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_OFFS, 32'h0);
      wr(ADDR_CFG, 32'h0);
      wr(ADDR_SIGT, 32'h2);
      wr(ADDR_CTRL, 32'h1);
      src(3000, 12000, 1'b0);
      check("current input", 32'(cmd_value), 32'd6000);
      rd("cmd register", ADDR_CMD, 32'd6000);
      $display("Test scaling finished");
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_SIGT, 32'h3);
      wr(ADDR_MASK, 32'h1);
      wr(ADDR_STAT, 32'h7);
      wr(ADDR_CTRL, 32'h1);
      src(0, 2000, 1'b0);
      check("break undetected", 32'(cable_break), 32'h0);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_CFG, 32'h2);
      wr(ADDR_CTRL, 32'h1);
      src(0, 2000, 1'b0);
      check("cable break", 32'(cable_break), 32'h1);
      check("break irq", 32'(irq), 32'h1);
      wr(ADDR_STAT, 32'h1);
      rd("break cleared", ADDR_STAT, 32'h0);
      check("irq cleared", 32'(irq), 32'h0);
      wr(ADDR_MASK, 32'h0);
      src(0, 12000, 1'b0);
      src(0, 2000, 1'b0);
      rd("masked break", ADDR_STAT, 32'h1);
      check("irq masked", 32'(irq), 32'h0);
      wr(ADDR_CFG, 32'h0);
      $display("Test cable break finished");
      slow <= 1'b1;
      sol(32'h2, -3000, 1'b0, 3000, 0, 3000);
      sol(32'h1, 1000, 1'b0, 2000, 6000, 0);
      sol(32'h3, 4000, 1'b1, 8000, 0, 8000);
      sol(32'h3, 4000, 1'b0, 8000, 8000, 0);
      $display("Test modes finished");
      stop_test();
   end
endmodule
